// file: include/stfs_pkg.sv
// Constants, register map and carrier types of the supply and thermal fault supervisor.
package stfs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SC_FILTER_MS = 4;
    localparam int unsigned SC_FILTER_CYC = SC_FILTER_MS * (CLK_HZ / 1000);
    localparam int unsigned COOL_S = 1;
    localparam int unsigned COOL_CYC = COOL_S * CLK_HZ;
    localparam int unsigned BLANK_US = 10;
    localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BLANK_W = $clog2(BLANK_CYC + 1);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_LIVE = 12'h008;
    localparam logic [1:0] FAIL_OT = 2'h1;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic mainOk;
        logic vsUv;
        logic auxUv;
        logic auxOc;
        logic secUv;
        logic canUv;
        logic otSec;
        logic otAux;
        logic otCan;
        logic otLin;
        logic [3:0] otHs;
        logic temperature_prewarning_flag;
        logic global_shutdown_flag;
    } stfs_cmp_t;

    typedef struct packed {
        logic [3:0] hsEn;
        logic loadShare;
        logic stopKeepOn;
        logic uvOffOpt;
        logic [1:0] auxEn;
        logic [1:0] secEn;
    } stfs_ctrl_t;

    typedef struct packed {
        logic [3:0] hsFault;
        logic [1:0] linFail;
        logic [1:0] canFail;
        logic global_shutdown_flag;
        logic temperature_prewarning_flag;
        logic auxOt;
        logic secOt;
        logic blockOt;
        logic canSupplyUv;
        logic secUv;
        logic auxUv;
        logic auxOc;
        logic flagA;
        logic mainShort;
    } stfs_flags_t;

    localparam int unsigned CTRL_W = $bits(stfs_ctrl_t);
    localparam int unsigned FLAG_W = $bits(stfs_flags_t);
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

    typedef enum logic [1:0] {
        MS_RAMP = 2'h0,
        MS_ON = 2'h1,
        MS_DROP = 2'h3,
        MS_FAULT = 2'h2
    } stfs_main_t;

endpackage

// file: rtl/stfs_supervisor.sv
// Supply short-circuit, undervoltage and thermal fault supervisor with APB status registers.
`timescale 1ns/10ps
module stfs_supervisor #(
    parameter int unsigned SC_FILTER_CYCLES = stfs_pkg::SC_FILTER_CYC,
    parameter int unsigned COOL_CYCLES = stfs_pkg::COOL_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire stfs_pkg::stfs_cmp_t cmpRaw,
    input wire logic sleepExit,
    input wire logic wakeEvent,
    input wire logic normalMode,
    input wire logic stopMode,
    input wire logic canActive,
    input wire logic linActive,
    output logic mainSupplyOn,
    output logic failOutputsEn,
    output logic failSafeReq,
    output logic restartReq,
    output logic auxRegOn,
    output logic secRegOn,
    output logic canTxEn,
    output logic linTxEn,
    output logic [3:0] hsOn
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    stfs_pkg::stfs_cmp_t cmp;

    stfs_sync #(
        .WIDTH($bits(stfs_pkg::stfs_cmp_t))
    ) uSync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(cmpRaw),
        .dout(cmp)
    );

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    stfs_pkg::stfs_main_t mainState_q;
    stfs_pkg::stfs_ctrl_t ctrl_q;
    stfs_pkg::stfs_flags_t flags_q;
    stfs_pkg::stfs_flags_t flags_d;
    stfs_pkg::stfs_flags_t setF;
    stfs_pkg::stfs_flags_t clrOkF;
    stfs_pkg::stfs_flags_t clrReq;
    logic scRun, scClr, scDone;
    logic coolBusy_q, coolDone, tsd2Evt;
    logic auxLsOff_q, canOtOff_q, linOtOff_q;
    logic auxPassOk, anyOt;
    logic secOtEvt, auxSaOtEvt, auxLsOtEvt, canOtEvt, linOtEvt, hsOtEvt;
    logic [3:0] hsOtHit;
    logic auxOnPrev_q, secOnPrev_q;
    logic [stfs_pkg::BLANK_W-1:0] auxBlank_q, secBlank_q;
    logic wrAcc, ctrlWr, statWr, mapped;

    function automatic logic [stfs_pkg::BLANK_W-1:0] blankNext(
        input logic [stfs_pkg::BLANK_W-1:0] cnt,
        input logic trig
    );
        if (trig) begin
            return stfs_pkg::BLANK_W'(stfs_pkg::BLANK_CYC);
        end
        return (cnt != '0) ? stfs_pkg::BLANK_W'(cnt - 1'b1) : cnt;
    endfunction

    // ------------------------------------------------------------------
    // Main supply short-circuit supervision
    // ------------------------------------------------------------------
    assign scRun = ((mainState_q == stfs_pkg::MS_RAMP && !cmp.mainOk) ||
        mainState_q == stfs_pkg::MS_DROP) && !cmp.vsUv;
    assign scClr = (mainState_q == stfs_pkg::MS_ON) || (mainState_q == stfs_pkg::MS_FAULT) || sleepExit;

    stfs_timer #(
        .LIMIT(SC_FILTER_CYCLES)
    ) uScTimer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clr(scClr),
        .run(scRun),
        .done(scDone)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mainState_q <= stfs_pkg::MS_RAMP;
        end else begin
            unique case (mainState_q)
                stfs_pkg::MS_RAMP: begin
                    if (sleepExit) begin
                        mainState_q <= stfs_pkg::MS_RAMP;
                    end else if (cmp.mainOk) begin
                        mainState_q <= stfs_pkg::MS_ON;
                    end else if (scDone) begin
                        mainState_q <= stfs_pkg::MS_FAULT;
                    end
                end
                stfs_pkg::MS_ON: begin
                    if (sleepExit) begin
                        mainState_q <= stfs_pkg::MS_RAMP;
                    end else if (!cmp.mainOk) begin
                        mainState_q <= stfs_pkg::MS_DROP;
                    end
                end
                stfs_pkg::MS_DROP: begin
                    if (sleepExit) begin
                        mainState_q <= stfs_pkg::MS_RAMP;
                    end else if (cmp.mainOk) begin
                        mainState_q <= stfs_pkg::MS_ON;
                    end else if (scDone) begin
                        mainState_q <= stfs_pkg::MS_FAULT;
                    end
                end
                stfs_pkg::MS_FAULT: begin
                    if (wakeEvent) begin
                        mainState_q <= stfs_pkg::MS_RAMP;
                    end
                end
            endcase
        end
    end

    assign mainSupplyOn = (mainState_q != stfs_pkg::MS_FAULT);
    assign failOutputsEn = (mainState_q == stfs_pkg::MS_FAULT);

    // ------------------------------------------------------------------
    // Global thermal shutdown and cool-down
    // ------------------------------------------------------------------
    assign tsd2Evt = cmp.global_shutdown_flag && mainSupplyOn && !coolBusy_q;

    stfs_timer #(
        .LIMIT(COOL_CYCLES)
    ) uCoolTimer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clr(!coolBusy_q),
        .run(coolBusy_q),
        .done(coolDone)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            coolBusy_q <= 1'b0;
            restartReq <= 1'b0;
        end else begin
            coolBusy_q <= tsd2Evt || (coolBusy_q && !coolDone);
            restartReq <= coolDone;
        end
    end

    assign failSafeReq = failOutputsEn || coolBusy_q;

    // ------------------------------------------------------------------
    // Stage enables and thermal events
    // ------------------------------------------------------------------
    always_comb begin
        if (ctrl_q.loadShare) begin
            auxPassOk = !((cmp.vsUv && !ctrl_q.uvOffOpt) || (stopMode && !ctrl_q.stopKeepOn));
        end else begin
            auxPassOk = !(cmp.auxUv && !ctrl_q.uvOffOpt) && !cmp.vsUv;
        end
    end

    assign secRegOn = |ctrl_q.secEn;
    assign auxRegOn = |ctrl_q.auxEn && !auxLsOff_q && auxPassOk;
    assign hsOn = ctrl_q.hsEn;
    assign canTxEn = canActive && !canOtOff_q;
    assign linTxEn = linActive && !linOtOff_q;

    assign secOtEvt = secRegOn && cmp.otSec;
    assign auxSaOtEvt = !ctrl_q.loadShare && auxRegOn && cmp.otAux;
    assign auxLsOtEvt = ctrl_q.loadShare && auxRegOn && cmp.otAux;
    assign canOtEvt = canActive && cmp.otCan;
    assign linOtEvt = linActive && cmp.otLin;
    assign hsOtHit = hsOn & cmp.otHs;
    assign hsOtEvt = |hsOtHit;
    assign anyOt = cmp.otSec || cmp.otAux || cmp.otCan || cmp.otLin || (|cmp.otHs);

    // The load-sharing regulator and the transmitters return by themselves once cool.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            auxLsOff_q <= 1'b0;
            canOtOff_q <= 1'b0;
            linOtOff_q <= 1'b0;
        end else begin
            auxLsOff_q <= auxLsOtEvt || (auxLsOff_q && cmp.otAux && ctrl_q.loadShare);
            canOtOff_q <= canOtEvt;
            linOtOff_q <= linOtEvt;
        end
    end

    // ------------------------------------------------------------------
    // Blanking of undervoltage flags: aux after turn-on, secondary after either switching edge
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            auxOnPrev_q <= 1'b0;
            secOnPrev_q <= 1'b0;
            auxBlank_q <= '0;
            secBlank_q <= '0;
        end else begin
            auxOnPrev_q <= auxRegOn;
            secOnPrev_q <= secRegOn;
            auxBlank_q <= blankNext(auxBlank_q, auxRegOn && !auxOnPrev_q);
            secBlank_q <= blankNext(secBlank_q, secRegOn != secOnPrev_q);
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign pready = 1'b1;
    assign wrAcc = psel && penable && pwrite;
    assign ctrlWr = wrAcc && (paddr == stfs_pkg::ADDR_CTRL);
    assign statWr = wrAcc && (paddr == stfs_pkg::ADDR_STAT);
    assign mapped = (paddr == stfs_pkg::ADDR_CTRL) || (paddr == stfs_pkg::ADDR_STAT) ||
        (paddr == stfs_pkg::ADDR_LIVE);
    assign pslverr = psel && penable && !mapped;

    // Read data is sampled in the setup cycle so that it comes from a flip-flop.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            unique case (paddr)
                stfs_pkg::ADDR_CTRL: prdata <= 32'(ctrl_q);
                stfs_pkg::ADDR_STAT: prdata <= 32'(flags_q);
                stfs_pkg::ADDR_LIVE: prdata <= 32'({cmp, coolBusy_q, mainState_q});
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Hardware clears of enable bits win over a software write in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= stfs_pkg::CTRL_RST;
        end else begin
            if (ctrlWr) begin
                ctrl_q <= stfs_pkg::stfs_ctrl_t'(pwdata[stfs_pkg::CTRL_W-1:0]);
            end
            if (secOtEvt) begin
                ctrl_q.secEn <= 2'h0;
            end
            if (auxSaOtEvt) begin
                ctrl_q.auxEn <= 2'h0;
            end
            if (hsOtEvt) begin
                ctrl_q.hsEn <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------------
    always_comb begin
        setF = '0;
        setF.mainShort = scDone;
        setF.flagA = scDone;
        setF.auxOc = !ctrl_q.loadShare && auxRegOn && cmp.auxOc;
        setF.auxUv = !ctrl_q.loadShare && auxRegOn && auxBlank_q == '0 && cmp.auxUv;
        setF.secUv = secRegOn && secBlank_q == '0 && cmp.secUv;
        setF.canSupplyUv = cmp.canUv;
        setF.blockOt = secOtEvt || auxSaOtEvt || auxLsOtEvt || canOtEvt || linOtEvt || hsOtEvt;
        setF.secOt = secOtEvt;
        setF.auxOt = auxSaOtEvt || auxLsOtEvt;
        setF.temperature_prewarning_flag = mainSupplyOn && cmp.temperature_prewarning_flag;
        setF.global_shutdown_flag = tsd2Evt;
        setF.hsFault = hsOtEvt ? hsOn : 4'h0;
        setF.canFail = canOtEvt ? stfs_pkg::FAIL_OT : 2'h0;
        setF.linFail = linOtEvt ? stfs_pkg::FAIL_OT : 2'h0;
        clrOkF = '1;
        clrOkF.blockOt = !anyOt;
        clrOkF.temperature_prewarning_flag = !cmp.temperature_prewarning_flag;
        clrOkF.global_shutdown_flag = normalMode && !cmp.global_shutdown_flag;
        clrReq = statWr ? stfs_pkg::stfs_flags_t'(pwdata[stfs_pkg::FLAG_W-1:0]) : '0;
        flags_d = (flags_q & ~(clrReq & clrOkF)) | setF;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_ramp_timeout: assert property ((mainState_q == stfs_pkg::MS_RAMP && scDone && !sleepExit) |=>
        (failOutputsEn && flags_q.mainShort && flags_q.flagA && failSafeReq))
        else $error("ramp timeout did not enter fail-safe");
    chk_wake_only_exit: assert property ((failOutputsEn && !wakeEvent) |=> failOutputsEn)
        else $error("short fault left without wake");
    chk_drop_timeout: assert property ((mainState_q == stfs_pkg::MS_DROP && scDone && !sleepExit) |=>
        !mainSupplyOn)
        else $error("drop timeout did not switch main off");
    chk_sc_suspend: assert property ((mainState_q == stfs_pkg::MS_RAMP && cmp.vsUv && !sleepExit) |=>
        mainSupplyOn)
        else $error("short detected during battery undervoltage");
    chk_ls_pass_off: assert property ((ctrl_q.loadShare && stopMode && !ctrl_q.stopKeepOn) |-> !auxRegOn)
        else $error("load-sharing pass device on in stop");
    chk_sa_pass_off: assert property ((!ctrl_q.loadShare && cmp.auxUv && !ctrl_q.uvOffOpt) |-> !auxRegOn)
        else $error("stand-alone pass device on in undervoltage");
    chk_sec_uv_sticky: assert property ((flags_q.secUv && !statWr) |=> flags_q.secUv)
        else $error("secondary undervoltage flag lost");
    chk_can_uv_set: assert property (cmp.canUv |=> flags_q.canSupplyUv)
        else $error("transceiver supply flag not set");
    chk_sec_blank: assert property ((secBlank_q != '0) |=> !$rose(flags_q.secUv))
        else $error("secondary undervoltage flagged while switching");
    chk_sec_ot_off: assert property (secOtEvt |=> (!secRegOn && flags_q.secOt && flags_q.blockOt))
        else $error("secondary overtemperature not handled");
    chk_can_rx_only: assert property ((canActive && cmp.otCan) |=> (!canTxEn && flags_q.canFail == 2'h1))
        else $error("CAN transmitter not disabled");
    chk_hs_all_off: assert property (hsOtEvt |=> (hsOn == 4'h0 && flags_q.hsFault != 4'h0))
        else $error("high-side switches not all off");
    chk_global_shutdown_flag_cool: assert property (tsd2Evt |=> (failSafeReq && flags_q.global_shutdown_flag))
        else $error("global shutdown not entered");
    chk_global_shutdown_flag_keep: assert property ((flags_q.global_shutdown_flag && !normalMode) |=> flags_q.global_shutdown_flag)
        else $error("global flag cleared outside normal mode");

    cov_short_fault: cover property (mainState_q == stfs_pkg::MS_DROP ##1 failOutputsEn);
    cov_wake_exit: cover property (failOutputsEn && wakeEvent ##1 mainSupplyOn);
    cov_restart: cover property (coolDone ##1 restartReq);
    cov_hs_trip: cover property (hsOtEvt);

endmodule // stfs_supervisor

// file: rtl/stfs_sync.sv
// Two-stage synchroniser for a vector of independent comparator levels.
`timescale 1ns/10ps
module stfs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // Each bit is a slow level, so bitwise crossing is safe.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // stfs_sync

// file: rtl/stfs_timer.sv
// Up-counter that flags the cycle in which a run time reaches its terminal count.
`timescale 1ns/10ps
module stfs_timer #(
    parameter int unsigned LIMIT = 100
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic run,
    output logic done
);
    localparam int unsigned W = $clog2(LIMIT + 1);
    logic [W-1:0] cnt_q;

    // A paused count keeps its value; only clr restarts it.
    assign done = run && (cnt_q == W'(LIMIT - 1));

    always_ff @(posedge core_clk) begin
        if (!rst_n || clr) begin
            cnt_q <= '0;
        end else if (run && !done) begin
            cnt_q <= W'(cnt_q + 1'b1);
        end
    end
endmodule // stfs_timer

// file: verification/stfs_host_model.sv
// Host-side APB master that reads and clears the supervisor's status flags.
`timescale 1ns/10ps
module stfs_host_model (
    input wire logic core_clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [11:0] paddr = 12'h000,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [31:0] pwdata = 32'h0
);
    // The request is held until pready is seen high, however slow the answer.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Flags are only dropped by writing ones; the device never drops them itself.
    task automatic clr(input logic [31:0] bits);
        logic [31:0] r;
        logic e;
        xfer(1'b1, stfs_pkg::ADDR_STAT, bits, r, e);
    endtask
endmodule // stfs_host_model

// file: verification/supply_thermal_fault_supervisor_tb_top.sv
// Self-checking testbench for the supply and thermal fault supervisor.
`timescale 1ns/10ps
module supply_thermal_fault_supervisor_tb_top;
    localparam logic [11:0] ST = stfs_pkg::ADDR_STAT;
    logic core_clk;
    logic rst_n;
    stfs_pkg::stfs_cmp_t cmp;
    logic sleepExit;
    logic wakeEvent;
    logic normalMode;
    logic stopMode;
    logic canActive;
    logic linActive;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, se;
    logic [31:0] pwdata, prdata, rd;
    logic mainSupplyOn, failOutputsEn, failSafeReq, restartReq, auxRegOn, secRegOn, canTxEn, linTxEn;
    logic [3:0] hsOn;
    logic [11:0] outs;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    assign outs = {mainSupplyOn, failOutputsEn, failSafeReq, restartReq, auxRegOn, secRegOn, canTxEn, linTxEn, hsOn};
    always #20 core_clk = ~core_clk;

    stfs_host_model host (.core_clk(core_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
    stfs_supervisor #(.SC_FILTER_CYCLES(20), .COOL_CYCLES(30)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmpRaw(cmp), .sleepExit(sleepExit), .wakeEvent(wakeEvent),
        .normalMode(normalMode), .stopMode(stopMode), .canActive(canActive), .linActive(linActive),
        .mainSupplyOn(mainSupplyOn), .failOutputsEn(failOutputsEn), .failSafeReq(failSafeReq),
        .restartReq(restartReq), .auxRegOn(auxRegOn), .secRegOn(secRegOn), .canTxEn(canTxEn),
        .linTxEn(linTxEn), .hsOn(hsOn));

    task automatic tally_and_finish;
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Outputs are looked at on the falling edge, once the rising edge's updates have landed.
    task automatic see(input logic [11:0] mask, input logic [11:0] exp);
        @(negedge core_clk);
        chk({20'h0, outs & mask}, {20'h0, exp});
        @(posedge core_clk);
    endtask
    task automatic st(input logic [31:0] mask, input logic [31:0] exp);
        host.xfer(1'b0, ST, 32'h0, rd, se);
        chk(rd & mask, exp);
    endtask
    task automatic wrCtrl(input logic [31:0] d);
        host.xfer(1'b1, stfs_pkg::ADDR_CTRL, d, rd, se);
    endtask
    task automatic recover;
        wakeEvent <= 1'b1;
        cmp.mainOk <= 1'b1;
        cyc(1);
        wakeEvent <= 1'b0;
        cyc(6);
    endtask

    task automatic tMainShort;
        st(32'hffffffff, 32'h0);
        host.xfer(1'b0, 12'h00c, 32'h0, rd, se);
        chk({31'h0, se}, 32'h1);
        cyc(30);
        see(12'h800, 12'h800);
        cmp.vsUv <= 1'b0;
        cyc(30);
        see(12'he00, 12'h600);
        st(32'h3, 32'h3);
        sleepExit <= 1'b1;
        cyc(1);
        sleepExit <= 1'b0;
        cyc(4);
        see(12'h800, 12'h000);
        recover();
        see(12'he00, 12'h800);
        host.clr(32'h3);
    endtask
    task automatic tMainDrop;
        cmp.mainOk <= 1'b0;
        cyc(10);
        cmp.mainOk <= 1'b1;
        cyc(20);
        see(12'h800, 12'h800);
        cmp.mainOk <= 1'b0;
        cyc(30);
        see(12'hc00, 12'h400);
        recover();
        host.clr(32'h3);
    endtask
    task automatic tSecUv;
        wrCtrl(32'h1);
        cmp.secUv <= 1'b1;
        cmp.canUv <= 1'b1;
        cyc(20);
        cmp.secUv <= 1'b0;
        cmp.canUv <= 1'b0;
        st(32'h30, 32'h20);
        cyc(250);
        cmp.secUv <= 1'b1;
        cyc(5);
        cmp.secUv <= 1'b0;
        cyc(5);
        st(32'h30, 32'h30);
        host.clr(32'h30);
        st(32'h30, 32'h0);
    endtask
    task automatic tSecOt;
        wrCtrl(32'h0);
        cmp.otSec <= 1'b1;
        cyc(6);
        st(32'hc0, 32'h0);
        wrCtrl(32'h1);
        cyc(6);
        see(12'h40, 12'h0);
        host.xfer(1'b0, stfs_pkg::ADDR_CTRL, 32'h0, rd, se);
        chk(rd & 32'h3, 32'h0);
        host.clr(32'h40);
        st(32'hc0, 32'hc0);
        cmp.otSec <= 1'b0;
        cyc(6);
        st(32'hc0, 32'hc0);
        host.clr(32'hc0);
        st(32'hc0, 32'h0);
    endtask
    task automatic tCanLin;
        canActive <= 1'b1;
        linActive <= 1'b1;
        cyc(2);
        see(12'h30, 12'h30);
        cmp.otCan <= 1'b1;
        cmp.otLin <= 1'b1;
        cyc(5);
        see(12'h30, 12'h0);
        st(32'h7840, 32'h2840);
        cmp.otCan <= 1'b0;
        cmp.otLin <= 1'b0;
        cyc(5);
        see(12'h30, 12'h30);
        host.clr(32'h7840);
        st(32'h7840, 32'h0);
    endtask
    task automatic tHs;
        wrCtrl(32'h280);
        see(12'hf, 12'h5);
        cmp.otHs <= 4'h4;
        cyc(5);
        see(12'hf, 12'h0);
        st(32'h78040, 32'h28040);
        cmp.otHs <= 4'h0;
        cyc(5);
        see(12'hf, 12'h0);
        host.clr(32'h78040);
        st(32'h78040, 32'h0);
    endtask
    // Load-sharing first, then stand-alone; the undervoltage flag is checked inside and after its blanking time.
    task automatic tAux;
        wrCtrl(32'h4c);
        see(12'h80, 12'h80);
        stopMode <= 1'b1;
        cyc(1);
        see(12'h80, 12'h0);
        stopMode <= 1'b0;
        cmp.otAux <= 1'b1;
        cyc(4);
        see(12'h80, 12'h0);
        cmp.otAux <= 1'b0;
        cyc(4);
        see(12'h80, 12'h80);
        st(32'h140, 32'h140);
        host.clr(32'h140);
        st(32'h140, 32'h0);
        wrCtrl(32'h1c);
        cmp.auxUv <= 1'b1;
        cmp.auxOc <= 1'b1;
        cyc(4);
        see(12'h80, 12'h80);
        st(32'hc, 32'h4);
        cyc(250);
        st(32'hc, 32'hc);
        wrCtrl(32'hc);
        see(12'h80, 12'h0);
        cmp.auxUv <= 1'b0;
        cmp.auxOc <= 1'b0;
        cmp.vsUv <= 1'b1;
        cyc(4);
        see(12'h80, 12'h0);
        cmp.vsUv <= 1'b0;
        cyc(3);
        see(12'h80, 12'h80);
        cmp.otAux <= 1'b1;
        cyc(4);
        see(12'h80, 12'h0);
        cmp.otAux <= 1'b0;
        host.xfer(1'b0, stfs_pkg::ADDR_CTRL, 32'h0, rd, se);
        chk(rd & 32'hc, 32'h0);
        host.clr(32'h14c);
        st(32'h14c, 32'h0);
        cmp.temperature_prewarning_flag <= 1'b1;
        cyc(3);
        host.clr(32'h200);
        st(32'h200, 32'h200);
        cmp.temperature_prewarning_flag <= 1'b0;
        cyc(3);
        host.clr(32'h200);
        st(32'h200, 32'h0);
    endtask
    task automatic tTsd2;
        int n = 0;
        normalMode <= 1'b0;
        cmp.global_shutdown_flag <= 1'b1;
        cyc(4);
        cmp.global_shutdown_flag <= 1'b0;
        see(12'h200, 12'h200);
        st(32'h400, 32'h400);
        host.clr(32'h400);
        st(32'h400, 32'h400);
        do begin
            @(negedge core_clk);
            n++;
        end while (outs[8] !== 1'b1 && n < 80);
        chk({20'h0, outs & 12'h300}, 32'h100);
        @(posedge core_clk);
        normalMode <= 1'b1;
        host.clr(32'h400);
        st(32'h400, 32'h0);
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n <= 1'b0;
        cmp <= '{vsUv: 1'b1, default: 1'b0};
        sleepExit <= 1'b0;
        wakeEvent <= 1'b0;
        normalMode <= 1'b1;
        stopMode <= 1'b0;
        canActive <= 1'b0;
        linActive <= 1'b0;
        cyc(5);
        rst_n <= 1'b1;
        tMainShort();
        tMainDrop();
        tSecUv();
        tSecOt();
        tCanLin();
        tHs();
        tAux();
        tTsd2();
        tally_and_finish();
    end
endmodule // supply_thermal_fault_supervisor_tb_top
